// ### common/rtc_slave_regs.vh
`ifndef RTC_SLAVE_REGS_VH
`define RTC_SLAVE_REGS_VH
// ----------------------------------------------------------------------
// Bus address and register map
// ----------------------------------------------------------------------
`define SLAVE_ADDR 7'h68
`define REG_COUNT 4'h8
`define REG_IDX_SECONDS 3'h0
`define REG_IDX_MINUTES 3'h1
`define REG_IDX_HOURS 3'h2
`define REG_IDX_DAY 3'h3
`define REG_IDX_DATE 3'h4
`define REG_IDX_MONTH 3'h5
`define REG_IDX_YEARS 3'h6
`define REG_IDX_CONTROL 3'h7
`define REG_IDX_LAST 3'h7
`define REG_RESET_VAL 8'h00
`define BITS_PER_BYTE 4'h8
`define RD_BIT_POS 0
`define FIFO_DEPTH_DEF 32
`endif

// ### verilog/byte_fifo.v
`timescale 1ns/1ps
module byte_fifo #(
  parameter WIDTH = 11,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // Storage has no reset; only the pointers and the count need one.
  always @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule // byte_fifo

// ### verilog/rtc_two_wire_slave_port.v
`timescale 1ns/1ps
`include "rtc_slave_regs.vh"
module rtc_two_wire_slave_port #(
  parameter FIFO_DEPTH = `FIFO_DEPTH_DEF,
  parameter FIFO_AW = 5
) (
  input wire sys_clk,
  input wire rst_n,
  input wire scl_in,
  input wire sda_in,
  output reg sda_oe_n,
  input wire [7:0] load_data,
  input wire [2:0] load_idx,
  input wire load_valid,
  output reg [7:0] wr_data,
  output reg [2:0] wr_idx,
  output reg wr_valid,
  input wire wr_ready,
  output reg busy
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  reg scl_s1_q;
  reg scl_s2_q;
  reg scl_s3_q;
  reg sda_s1_q;
  reg sda_s2_q;
  reg sda_s3_q;
  reg scl_q;
  reg sda_q;

  // A pin change is believed only once the second and third stages agree.
  // The stages reset to the idle bus level, so no false edge follows reset.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_s3_q <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_s3_q <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s1_q <= scl_in;
      scl_s2_q <= scl_s1_q;
      scl_s3_q <= scl_s2_q;
      sda_s1_q <= sda_in;
      sda_s2_q <= sda_s1_q;
      sda_s3_q <= sda_s2_q;
      if (scl_s2_q == scl_s3_q) begin
        scl_q <= scl_s3_q;
      end
      if (sda_s2_q == sda_s3_q) begin
        sda_q <= sda_s3_q;
      end
    end
  end

  wire scl_now = (scl_s2_q == scl_s3_q) ? scl_s3_q : scl_q;
  wire sda_now = (sda_s2_q == sda_s3_q) ? sda_s3_q : sda_q;
  wire scl_rise = scl_now & ~scl_q;
  wire scl_fall = ~scl_now & scl_q;
  wire start_det = scl_q & scl_now & sda_q & ~sda_now;
  wire stop_det = scl_q & scl_now & ~sda_q & sda_now;

  // ----------------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------------
  reg [7:0] regs_q [0:7];
  reg [2:0] ptr_q;
  wire [2:0] ptr_next = (ptr_q == `REG_IDX_LAST) ? `REG_IDX_SECONDS : ptr_q + 3'h1;

  // ----------------------------------------------------------------------
  // Protocol state machine
  // ----------------------------------------------------------------------
  localparam [5:0] ST_IDLE = 6'h01;
  localparam [5:0] ST_ADDR = 6'h02;
  localparam [5:0] ST_WBYTE = 6'h04;
  localparam [5:0] ST_RBYTE = 6'h08;
  localparam [5:0] ST_ACK = 6'h10;
  localparam [5:0] ST_MACK = 6'h20;

  reg [5:0] state_q;
  reg [3:0] bit_q;
  reg [7:0] sh_q;
  reg rd_mode_q;
  reg first_wr_q;
  reg ack_next_rd_q;
  reg [2:0] push_idx_q;
  reg [7:0] push_byte_q;

  function [7:0] reg_at;
    input [2:0] idx;
    begin
      reg_at = regs_q[idx];
    end
  endfunction

  // The byte under the pointer, shifted out at the start of each read byte.
  wire [7:0] cur_byte = reg_at(ptr_q);

  // Written bytes leave through the FIFO; a full FIFO stops the device from
  // acknowledging, since the byte could not be kept.
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [10:0] fifo_out_data;
  reg fifo_push;
  wire fifo_take = fifo_out_valid & (~wr_valid | wr_ready);

  always @(posedge sys_clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rd_mode_q <= 1'b0;
      first_wr_q <= 1'b0;
      ack_next_rd_q <= 1'b0;
      ptr_q <= `REG_IDX_SECONDS;
      sda_oe_n <= 1'b1;
      busy <= 1'b0;
      fifo_push <= 1'b0;
      push_idx_q <= 3'h0;
      push_byte_q <= 8'h00;
    end else begin
      fifo_push <= 1'b0;
      if (stop_det) begin
        state_q <= ST_IDLE;
        sda_oe_n <= 1'b1;
        busy <= 1'b0;
      end else if (start_det) begin
        state_q <= ST_ADDR;
        bit_q <= 4'h0;
        sda_oe_n <= 1'b1;
        busy <= 1'b1;
      end else begin
        case (state_q)
          ST_ADDR, ST_WBYTE: begin
            if (scl_rise) begin
              sh_q <= {sh_q[6:0], sda_now};
              bit_q <= bit_q + 4'h1;
            end
            if (scl_fall && bit_q == `BITS_PER_BYTE) begin
              bit_q <= 4'h0;
              if (state_q == ST_ADDR) begin
                if (sh_q[7:1] == `SLAVE_ADDR) begin
                  rd_mode_q <= sh_q[`RD_BIT_POS];
                  first_wr_q <= ~sh_q[`RD_BIT_POS];
                  sda_oe_n <= 1'b0;
                  state_q <= ST_ACK;
                end else begin
                  state_q <= ST_IDLE;
                  busy <= 1'b0;
                end
              end else if (first_wr_q) begin
                ptr_q <= sh_q[2:0];
                first_wr_q <= 1'b0;
                sda_oe_n <= 1'b0;
                state_q <= ST_ACK;
              end else if (fifo_in_ready) begin
                fifo_push <= 1'b1;
                push_idx_q <= ptr_q;
                push_byte_q <= sh_q;
                ptr_q <= ptr_next;
                sda_oe_n <= 1'b0;
                state_q <= ST_ACK;
              end else begin
                state_q <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            // Held low until the ninth pulse has fallen.
            if (scl_fall) begin
              if (rd_mode_q) begin
                // The first bit goes out on the fall that ends the acknowledge
                // pulse, so it has settled long before the next rise.
                sda_oe_n <= cur_byte[7];
                sh_q <= {cur_byte[6:0], 1'b0};
                bit_q <= 4'h1;
                state_q <= ST_RBYTE;
              end else begin
                sda_oe_n <= 1'b1;
                state_q <= ST_WBYTE;
              end
            end
          end
          ST_RBYTE: begin
            if (scl_fall) begin
              if (bit_q == `BITS_PER_BYTE) begin
                sda_oe_n <= 1'b1;
                ptr_q <= ptr_next;
                state_q <= ST_MACK;
              end else begin
                sda_oe_n <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
                bit_q <= bit_q + 4'h1;
              end
            end
          end
          ST_MACK: begin
            // The master's answer is taken on the rise; the next byte follows the fall.
            if (scl_rise) begin
              ack_next_rd_q <= ~sda_now;
            end
            if (scl_fall) begin
              if (ack_next_rd_q) begin
                sda_oe_n <= cur_byte[7];
                sh_q <= {cur_byte[6:0], 1'b0};
                bit_q <= 4'h1;
                state_q <= ST_RBYTE;
              end else begin
                sda_oe_n <= 1'b1;
                state_q <= ST_IDLE;
              end
            end
          end
          ST_IDLE: begin
            // Nothing is driven until a START names this device.
            sda_oe_n <= 1'b1;
          end
          default: begin
            state_q <= ST_IDLE;
            sda_oe_n <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // Register storage: time keeper loads, bus writes taken as they enter the FIFO
  // ----------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_reg
      always @(posedge sys_clk) begin
        if (!rst_n) begin
          regs_q[gi] <= `REG_RESET_VAL;
        end else if (fifo_push && push_idx_q == gi) begin
          // A bus write wins over a time-keeper load in the same cycle.
          regs_q[gi] <= push_byte_q;
        end else if (load_valid && load_idx == gi) begin
          regs_q[gi] <= load_data;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Write FIFO and write port
  // ----------------------------------------------------------------------
  byte_fifo #(
    .WIDTH(11),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .in_valid(fifo_push),
    .in_ready(fifo_in_ready),
    .in_data({push_idx_q, push_byte_q}),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_take),
    .out_data(fifo_out_data)
  );

  // A word stands until the consumer takes it; the next one loads on that edge.
  always @(posedge sys_clk) begin
    if (!rst_n) begin
      wr_valid <= 1'b0;
      wr_data <= 8'h00;
      wr_idx <= 3'h0;
    end else if (fifo_take) begin
      wr_valid <= 1'b1;
      wr_data <= fifo_out_data[7:0];
      wr_idx <= fifo_out_data[10:8];
    end else if (wr_ready) begin
      wr_valid <= 1'b0;
    end
  end
endmodule // rtc_two_wire_slave_port

// ### sim/rtc_port_monitor.sv
`timescale 1ns/1ps
module rtc_port_monitor (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] wr_idx,
  input wire logic wr_valid,
  input wire logic wr_ready,
  input wire logic busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  sequence start_s;
    scl_in && sda_in ##1 scl_in && !sda_in;
  endsequence
  sequence stop_s;
    scl_in && !sda_in ##1 scl_in && sda_in;
  endsequence
  chk_start_quiet: assert property (start_s |=> sda_oe_n [*8])
    else $error("drive after start");
  chk_stop_idle: assert property (stop_s |-> ##[0:8] (!busy && sda_oe_n))
    else $error("stop ignored");
  // The pins pass a three-stage synchroniser, so a change lags the clock fall.
  chk_oe_in_low: assert property ($changed(sda_oe_n) |-> $past(!scl_in, 2))
    else $error("drive change outside clock low");
  chk_oe_hold_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("drive change in clock high");
  chk_ack_steady: assert property ($rose(scl_in) && !sda_oe_n |-> !sda_oe_n [*3])
    else $error("low not steady");
  chk_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_idx, wr_data}))
    else $error("write word not held");
  chk_wr_drop: assert property ($fell(wr_valid) |-> $past(wr_ready))
    else $error("write word lost");
  chk_busy_ack: assert property ($fell(sda_oe_n) |-> busy)
    else $error("address ack without busy");
endmodule // rtc_port_monitor
bind rtc_two_wire_slave_port rtc_port_monitor mon (.sys_clk(sys_clk), .rst_n(rst_n),
  .scl_in(scl_in), .sda_in(sda_in), .sda_oe_n(sda_oe_n), .wr_data(wr_data),
  .wr_idx(wr_idx), .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy));

// ### sim/two_wire_master_model.sv
`timescale 1ns/1ps
module two_wire_master_model (
  input wire logic sys_clk,
  input wire logic sda,
  output logic scl,
  output logic sda_drv
);
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tk(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic start();
    sda_drv = 1'b1;
    scl = 1'b1;
    tk(8);
    sda_drv = 1'b0;
    tk(4);
    scl = 1'b0;
    tk(2);
  endtask
  task automatic stop();
    sda_drv = 1'b0;
    tk(2);
    scl = 1'b1;
    tk(4);
    sda_drv = 1'b1;
    tk(8);
  endtask
  // Low phase is kept long so the device's lagging answer settles before the rise.
  task automatic bitx(input logic b, output logic r);
    sda_drv = b;
    tk(4);
    scl = 1'b1;
    tk(2);
    r = sda;
    scl = 1'b0;
    tk(2);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitx(d[i], r);
    bitx(1'b1, r);
    ack = !r;
  endtask
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bitx(1'b1, r);
      d[i] = r;
    end
    bitx(last, r);
  endtask
endmodule // two_wire_master_model

// ### sim/tb.sv
`timescale 1ns/1ps
module tb;
  logic sys_clk = 1'b0, rst_n = 1'b0, load_valid = 1'b0, wr_ready = 1'b1;
  logic [7:0] load_data = 8'h00, wr_data, rd;
  logic [2:0] load_idx = 3'h0, wr_idx;
  logic scl, sda_drv, sda_oe_n, wr_valid, busy, ack;
  logic [10:0] q[$];
  logic [7:0] bcd[8] = '{8'h59, 8'h42, 8'h23, 8'h07, 8'h31, 8'h12, 8'h99, 8'h10};
  int fails = 0, num_checks = 0, n;
  wire sda = sda_drv & sda_oe_n;
  initial forever #12.5 sys_clk = ~sys_clk;
  rtc_two_wire_slave_port dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda),
    .sda_oe_n(sda_oe_n), .load_data(load_data), .load_idx(load_idx), .load_valid(load_valid),
    .wr_data(wr_data), .wr_idx(wr_idx), .wr_valid(wr_valid), .wr_ready(wr_ready), .busy(busy));
  two_wire_master_model m (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  always @(posedge sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) q.push_back({wr_idx, wr_data});
  end
  task automatic note(input bit ok);
    num_checks++;
    if (!ok) begin
      fails++;
      $display("[FAIL] %0t mismatch", $time);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    note(got === exp);
  endtask
  task automatic chk_val(input logic [10:0] got, input logic [10:0] exp);
    note(got === exp);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic wr_ptr(input logic [7:0] p);
    m.start();
    m.wbyte(8'hD0, ack);
    chk_bit(ack, 1'b1);
    m.wbyte(p, ack);
    chk_bit(ack, 1'b1);
  endtask
  task automatic s_wrong_addr();
    m.start();
    m.wbyte(8'hA0, ack);
    chk_bit(ack, 1'b0);
    chk_bit(busy, 1'b0);
    m.stop();
  endtask
  task automatic s_load_read();
    for (int i = 0; i < 8; i++) begin
      load_idx = i[2:0];
      load_data = bcd[i];
      load_valid = 1'b1;
      @(negedge sys_clk);
    end
    load_valid = 1'b0;
    wr_ptr(8'h00);
    m.stop();
    m.start();
    m.wbyte(8'hD1, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < 9; i++) begin
      m.rbyte(i == 8, rd);
      chk_val({3'h0, rd}, {3'h0, bcd[i % 8]});
    end
    m.tk(6);
    chk_bit(sda_oe_n, 1'b1);
    m.stop();
  endtask
  task automatic s_write_wrap();
    q.delete();
    wr_ptr(8'h06);
    for (int i = 0; i < 3; i++) begin
      m.wbyte(8'(8'h45 + i), ack);
      chk_bit(ack, 1'b1);
    end
    m.stop();
    chk_bit(q.size() == 3, 1'b1);
    for (int i = 0; i < 3; i++) chk_val(q[i], {3'(i + 6), 8'(8'h45 + i)});
    wr_ptr(8'h06);
    m.stop();
    m.start();
    m.wbyte(8'hD1, ack);
    chk_bit(ack, 1'b1);
    for (int i = 0; i < 3; i++) begin
      m.rbyte(i == 2, rd);
      chk_val({3'h0, rd}, {3'h0, 8'(8'h45 + i)});
    end
    m.stop();
  endtask
  // A stalled consumer must end in a refused byte, never in a lost one.
  task automatic s_fifo_full();
    q.delete();
    wr_ready = 1'b0;
    wr_ptr(8'h00);
    n = 0;
    ack = 1'b1;
    while (ack === 1'b1 && n < 40) begin
      m.wbyte(n[7:0], ack);
      if (ack === 1'b1) n++;
    end
    m.stop();
    chk_bit(n == 33, 1'b1);
    wr_ready = 1'b1;
    for (int i = 0; i < 200 && q.size() < n; i++) @(negedge sys_clk);
    chk_bit(q.size() == n, 1'b1);
    for (int i = 0; i < n; i++) chk_val(q[i], {3'(i), 8'(i)});
  endtask
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    s_wrong_addr();
    s_load_read();
    s_write_wrap();
    s_fifo_full();
    final_report();
  end
  initial begin
    repeat (100000) @(posedge sys_clk);
    fails++;
    final_report();
  end
endmodule // tb
